/* core/led_pwm_intensity_control.sv */
/*
 * LED PWM intensity control for eight open-drain ports and a ninth output.
 * Holds the master/global and individual intensity registers, picks each
 * output's code and phase level, and runs nine PWM channels off one frame.
 * Assumes the serial host logic drives the register port on clk, and that
 * the configuration and blink phase registers live outside and feed the
 * global, blink and phase inputs on the same clock.
 */
// Functional notes
// - master nibble zero makes every output static
// - nonzero master, global clear: individual codes apply
// - code F static, codes 0..E run PWM
// - global set: all codes from master register
// - global mode covers every output together
// - phase zero: low for code plus one sixteenths
// - phase one: low for fifteen minus code
// - code F: phase zero low, one released
// - ninth output has its own phase bits
// - 240 steps, 15 slots, master gates slots
// - full code ignores gating, follows phase level
// - low nibble: ninth code, or global code
// - blink flip with blink enable selects phase one bits
`timescale 1ns/1ps

module led_pwm_intensity_control #(
    parameter int STEP_CYCLES = led_pwm_pkg::STEP_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_addr,
    input  wire logic [7:0] wr_data,
    input  wire logic       rd_en,
    input  wire logic [7:0] rd_addr,
    output logic      [7:0] rd_data,
    output logic            rd_valid,
    input  wire logic       global_flag,
    input  wire logic       blink_enable,
    input  wire logic       blink_flip,
    input  wire logic [7:0] phase0,
    input  wire logic [7:0] phase1,
    input  wire logic       ninth_phase0,
    input  wire logic       ninth_phase1,
    output logic      [7:0] port_pin_out,
    output logic      [7:0] port_pin_oe,
    output logic            ninth_output_out,
    output logic            ninth_output_oe
);

    localparam int NO = led_pwm_pkg::NUM_OUTPUTS;
    localparam int NP = led_pwm_pkg::NUM_PORTS;

    typedef struct packed {
        logic [7:0]      master_global;
        logic [3:0][7:0] port_int;
        logic [7:0]      rd_data;
        logic            rd_valid;
        logic [8:0]      pin_value;
    } top_state_t;

    top_state_t s_reg;
    top_state_t s_next;

    logic [3:0]    master;
    logic [3:0]    low_nibble;
    logic          run;
    logic          use_global;
    logic          blink_sel;
    logic [NO-1:0][3:0] code;
    logic [NO-1:0] level;
    logic [NO-1:0] drive_low;
    logic          tick;
    logic [3:0]    slot;
    logic [3:0]    cyc;

    // register port
    always_comb
    begin
        s_next = s_reg;
        s_next.rd_valid = rd_en;
        // open-drain pins only ever drive low
        s_next.pin_value = '0;
        if (wr_en)
        begin
            if (wr_addr == led_pwm_pkg::MASTER_GLOBAL_ADDR)
                s_next.master_global = wr_data;
            else if (wr_addr >= led_pwm_pkg::PORT_INT_FIRST_ADDR &&
                     wr_addr <= led_pwm_pkg::PORT_INT_LAST_ADDR)
                s_next.port_int[wr_addr[1:0]] = wr_data;
        end
        if (rd_en)
        begin
            if (rd_addr == led_pwm_pkg::MASTER_GLOBAL_ADDR)
                s_next.rd_data = s_reg.master_global;
            else if (rd_addr >= led_pwm_pkg::PORT_INT_FIRST_ADDR &&
                     rd_addr <= led_pwm_pkg::PORT_INT_LAST_ADDR)
                s_next.rd_data = s_reg.port_int[rd_addr[1:0]];
            else
                s_next.rd_data = led_pwm_pkg::UNMAPPED_READ;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_reg.master_global <= led_pwm_pkg::MASTER_GLOBAL_RESET;
            s_reg.port_int      <= {4{led_pwm_pkg::PORT_INT_RESET}};
            s_reg.rd_data       <= 8'h00;
            s_reg.rd_valid      <= 1'b0;
            s_reg.pin_value     <= 9'h000;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // read-back answers one clock after the strobe
    a_read_strobe: assert property (@(posedge clk) disable iff (rst)
        rd_en |=> rd_valid)
        else $error("read strobe not answered");

    a_read_single: assert property (@(posedge clk) disable iff (rst)
        !rd_en |=> !rd_valid)
        else $error("read valid without a strobe");

    a_read_hold: assert property (@(posedge clk) disable iff (rst)
        !rd_en |=> $stable(rd_data))
        else $error("read data moved without a strobe");

    a_read_master: assert property (@(posedge clk) disable iff (rst)
        (rd_en && rd_addr == led_pwm_pkg::MASTER_GLOBAL_ADDR) |=>
            (rd_data == $past(s_reg.master_global)))
        else $error("master register read back wrong");

    a_read_port: assert property (@(posedge clk) disable iff (rst)
        (rd_en && rd_addr >= led_pwm_pkg::PORT_INT_FIRST_ADDR &&
         rd_addr <= led_pwm_pkg::PORT_INT_LAST_ADDR) |=>
            (rd_data == $past(s_reg.port_int[rd_addr[1:0]])))
        else $error("intensity register read back wrong");

    a_read_unmapped: assert property (@(posedge clk) disable iff (rst)
        (rd_en && rd_addr != led_pwm_pkg::MASTER_GLOBAL_ADDR &&
         (rd_addr < led_pwm_pkg::PORT_INT_FIRST_ADDR ||
          rd_addr > led_pwm_pkg::PORT_INT_LAST_ADDR)) |=>
            (rd_data == led_pwm_pkg::UNMAPPED_READ))
        else $error("unmapped read not answered with default");

    a_write_master: assert property (@(posedge clk) disable iff (rst)
        (wr_en && wr_addr == led_pwm_pkg::MASTER_GLOBAL_ADDR) |=>
            (s_reg.master_global == $past(wr_data)))
        else $error("master register write lost");

    a_write_port: assert property (@(posedge clk) disable iff (rst)
        (wr_en && wr_addr >= led_pwm_pkg::PORT_INT_FIRST_ADDR &&
         wr_addr <= led_pwm_pkg::PORT_INT_LAST_ADDR) |=>
            (s_reg.port_int[$past(wr_addr[1:0])] == $past(wr_data)))
        else $error("intensity register write lost");

    a_write_other: assert property (@(posedge clk) disable iff (rst)
        (!wr_en || (wr_addr != led_pwm_pkg::MASTER_GLOBAL_ADDR &&
         (wr_addr < led_pwm_pkg::PORT_INT_FIRST_ADDR ||
          wr_addr > led_pwm_pkg::PORT_INT_LAST_ADDR))) |=>
            ($stable(s_reg.master_global) && $stable(s_reg.port_int)))
        else $error("register changed without a mapped write");

    assign master     = s_reg.master_global[led_pwm_pkg::MASTER_LSB +: led_pwm_pkg::NIBBLE_W];
    assign low_nibble = s_reg.master_global[0 +: led_pwm_pkg::NIBBLE_W];

    // master nibble zero stops all PWM
    assign run        = (master != led_pwm_pkg::MASTER_OFF);
    // global code only while master runs
    assign use_global = global_flag && run;
    // blink enable and blink flip together pick phase one bits
    assign blink_sel  = blink_enable && blink_flip;

    always_comb
    begin
        code  = '0;
        level = '0;
        for (int i = 0; i < NP; i++)
        begin
            // global code applied to every port
            if (use_global)
                code[i] = low_nibble;
            // two port codes per register, low nibble first
            else
                code[i] = s_reg.port_int[i / 2][(i % 2) * 4 +: 4];
            level[i] = blink_sel ? phase1[i] : phase0[i];
        end
        // low nibble is the ninth output's code
        code[NP] = low_nibble;
        // ninth output has its own phase bits
        level[NP] = blink_sel ? ninth_phase1 : ninth_phase0;
    end

    a_indiv_pairs: assert property (@(posedge clk) disable iff (rst)
        !use_global |-> (code[1] == s_reg.port_int[0][7:4]) &&
            (code[2] == s_reg.port_int[1][3:0]) &&
            (code[5] == s_reg.port_int[2][7:4]) && (code[6] == s_reg.port_int[3][3:0]))
        else $error("individual code pairing wrong");

    a_phase0_select: assert property (@(posedge clk) disable iff (rst)
        !(blink_enable && blink_flip) |->
            (level[NP-1:0] == phase0) && (level[NP] == ninth_phase0))
        else $error("phase zero bits not selected");

    a_ninth_own: assert property (@(posedge clk) disable iff (rst)
        ($stable(ninth_phase0) && $stable(ninth_phase1) && $stable(blink_sel)) |->
            $stable(level[NP]))
        else $error("ninth level moved without its own phase bits");

    pwm_timebase #(
        .STEP_CYCLES (STEP_CYCLES)
    ) u_timebase (
        .clk  (clk),
        .rst  (rst),
        .run  (run),
        .tick (tick),
        .slot (slot),
        .cyc  (cyc)
    );

    genvar g;
    generate
        for (g = 0; g < NO; g++)
        begin : g_chan
            // per-output channel mixes static and PWM
            pwm_channel u_chan (
                .clk       (clk),
                .rst       (rst),
                .tick      (tick),
                .run       (run),
                .master    (master),
                .slot      (slot),
                .cyc       (cyc),
                .code      (code[g]),
                .level     (level[g]),
                .drive_low (drive_low[g])
            );

            a_static_off: assert property (@(posedge clk) disable iff (rst)
                (!run && $past(!run) && !$past(rst)) |-> (drive_low[g] == !$past(level[g])))
                else $error("output not static while master is off");

            a_full_static: assert property (@(posedge clk) disable iff (rst)
                ($past(tick) && $past(code[g]) == 4'hF) |->
                    (drive_low[g] == !$past(level[g])))
                else $error("full code output not static");

            a_low_phase0: assert property (@(posedge clk) disable iff (rst)
                ($past(tick) && $past(run) && $past(code[g]) != 4'hF &&
                 !$past(level[g]) && $past(slot) < $past(master)) |->
                    (drive_low[g] == ($past(cyc) <= $past(code[g]))))
                else $error("phase zero low time wrong");

            a_low_phase1: assert property (@(posedge clk) disable iff (rst)
                ($past(tick) && $past(run) && $past(code[g]) != 4'hF &&
                 $past(level[g]) && $past(slot) < $past(master)) |->
                    (drive_low[g] == ($past(cyc) > $past(code[g]))))
                else $error("phase one low time wrong");

            a_gate_off: assert property (@(posedge clk) disable iff (rst)
                ($past(tick) && $past(run) && $past(code[g]) != 4'hF &&
                 $past(slot) >= $past(master)) |->
                    (drive_low[g] == $past(level[g])))
                else $error("ungated timeslot not idle");

            a_no_glitch: assert property (@(posedge clk) disable iff (rst)
                (run && $past(run) && !$past(tick)) |-> $stable(drive_low[g]))
                else $error("output moved between steps");
        end
    endgenerate

    a_global_code: assert property (@(posedge clk) disable iff (rst)
        (global_flag && run) |-> (code[NP-1:0] == {NP{low_nibble}}))
        else $error("global code not applied to all ports");

    a_indiv_code: assert property (@(posedge clk) disable iff (rst)
        !(global_flag && run) |-> (code[0] == s_reg.port_int[0][3:0]) &&
            (code[NP-1] == s_reg.port_int[3][7:4]))
        else $error("individual code not used");

    a_ninth_code: assert property (@(posedge clk) disable iff (rst)
        code[NP] == low_nibble)
        else $error("ninth output code not low nibble");

    a_phase_select: assert property (@(posedge clk) disable iff (rst)
        (blink_enable && blink_flip) |->
            (level[NP-1:0] == phase1) && (level[NP] == ninth_phase1))
        else $error("phase one bits not selected");

    a_write_effect: assert property (@(posedge clk) disable iff (rst)
        (wr_en && wr_addr == led_pwm_pkg::MASTER_GLOBAL_ADDR &&
         wr_data[7:4] == led_pwm_pkg::MASTER_OFF) |=> !run)
        else $error("master write did not stop pwm");

    a_restart_start: assert property (@(posedge clk) disable iff (rst)
        (run && !$past(run)) |-> (slot == 4'h0) && (cyc == 4'h0) && !tick)
        else $error("pwm did not restart at period start");

    a_stop_all: assert property (@(posedge clk) disable iff (rst)
        (!run && !$past(run) && !$past(rst)) |->
            (port_pin_oe == ~$past(level[NP-1:0])))
        else $error("ports not static while master is off");

    assign rd_data          = s_reg.rd_data;
    assign rd_valid         = s_reg.rd_valid;
    assign port_pin_out     = s_reg.pin_value[NP-1:0];
    assign ninth_output_out = s_reg.pin_value[NP];
    // drive_low comes straight from each channel flop
    assign port_pin_oe      = drive_low[NP-1:0];
    assign ninth_output_oe  = drive_low[NP];

endmodule

/* core/led_pwm_pkg.sv */
/*
 * Shared constants of the LED PWM intensity block: register offsets, nibble
 * positions, reset values, PWM frame shape and the oscillator step timing.
 * Assumes a single 250 MHz clock domain and an 8-bit register port.
 */
package led_pwm_pkg;

    // register offsets
    localparam logic [7:0] MASTER_GLOBAL_ADDR   = 8'h0E;
    localparam logic [7:0] PORT_INT_FIRST_ADDR  = 8'h10;
    localparam logic [7:0] PORT_INT_LAST_ADDR   = 8'h13;

    // reset values
    localparam logic [7:0] MASTER_GLOBAL_RESET  = 8'h00;
    localparam logic [7:0] PORT_INT_RESET       = 8'h00;
    localparam logic [7:0] UNMAPPED_READ        = 8'h00;

    // field layout
    localparam int         NIBBLE_W             = 4;
    localparam int         MASTER_LSB           = 4;
    localparam int         NUM_PORTS            = 8;
    localparam int         NUM_OUTPUTS          = 9;
    localparam int         NUM_PORT_REGS        = 4;

    // intensity codes
    localparam logic [3:0] STATIC_CODE          = 4'hF;
    localparam logic [3:0] MASTER_OFF           = 4'h0;

    // frame shape: 15 timeslots of 16 steps, 240 steps per period
    localparam logic [3:0] LAST_SLOT            = 4'hE;
    localparam logic [3:0] LAST_CYCLE           = 4'hF;
    localparam int         PERIOD_STEPS         = 240;

    // step timing, rounded down to whole clocks
    localparam int         CLK_PERIOD_NS        = 4;
    localparam int         OSC_HZ               = 32000;
    localparam int         OSC_PERIOD_NS        = 1000000000 / OSC_HZ;
    localparam int         STEP_CYCLES          = OSC_PERIOD_NS / CLK_PERIOD_NS;

endpackage

/* core/pwm_timebase.sv */
/*
 * PWM frame counter: divides the clock down to oscillator steps and tracks
 * the timeslot and the step inside it. Assumes run comes from same-clock
 * register logic.
 */
`timescale 1ns/1ps

module pwm_timebase #(
    parameter int STEP_CYCLES = led_pwm_pkg::STEP_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       run,
    output logic            tick,
    output logic [3:0]      slot,
    output logic [3:0]      cyc
);

    localparam int PW = $clog2(STEP_CYCLES + 1);

    typedef struct packed {
        logic [PW-1:0] presc;
        logic [3:0]    slot;
        logic [3:0]    cyc;
        logic          tick;
    } tb_state_t;

    tb_state_t s_reg;
    tb_state_t s_next;

    always_comb
    begin
        s_next = s_reg;
        s_next.tick = run && (s_reg.presc == '0);
        if (!run)
        begin
            s_next.presc = '0;
            s_next.slot  = '0;
            s_next.cyc   = '0;
            s_next.tick  = 1'b0;
        end
        else if (s_reg.presc == PW'(STEP_CYCLES - 1))
        begin
            // 16 steps per slot, 15 slots
            s_next.presc = '0;
            if (s_reg.cyc == led_pwm_pkg::LAST_CYCLE)
            begin
                s_next.cyc  = '0;
                s_next.slot = (s_reg.slot == led_pwm_pkg::LAST_SLOT) ? 4'h0 : s_reg.slot + 4'h1;
            end
            else
            begin
                s_next.cyc = s_reg.cyc + 4'h1;
            end
        end
        else
        begin
            s_next.presc = s_reg.presc + PW'(1);
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign tick = s_reg.tick;
    assign slot = s_reg.slot;
    assign cyc  = s_reg.cyc;

    a_counter_hold: assert property (@(posedge clk) disable iff (rst)
        !run |=> (slot == 4'h0) && (cyc == 4'h0) && !tick)
        else $error("frame counters not held while stopped");

    a_slot_wrap: assert property (@(posedge clk) disable iff (rst)
        (run && $past(run) && slot != $past(slot)) |->
            ($past(cyc) == 4'hF) && (cyc == 4'h0) &&
            (slot == (($past(slot) == 4'hE) ? 4'h0 : $past(slot) + 4'h1)))
        else $error("timeslot advance out of sequence");

endmodule

/* core/pwm_channel.sv */
/*
 * One open-drain PWM output: turns the frame position, the intensity code and
 * the phase level into a drive-low flop. Assumes the frame counter of
 * pwm_timebase and same-clock control inputs.
 */
`timescale 1ns/1ps

module pwm_channel (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       tick,
    input  wire logic       run,
    input  wire logic [3:0] master,
    input  wire logic [3:0] slot,
    input  wire logic [3:0] cyc,
    input  wire logic [3:0] code,
    input  wire logic       level,
    output logic            drive_low
);

    typedef struct packed {
        logic drive_low;
    } chan_state_t;

    chan_state_t s_reg;
    chan_state_t s_next;

    always_comb
    begin
        logic lvl;
        lvl = 1'b1;
        s_next = s_reg;
        // output moves only on step edges while running, and every clock while stopped
        if (!run || tick)
        begin
            if (!run || code == led_pwm_pkg::STATIC_CODE)
                lvl = level;
            // on-time is code plus one steps
            else if ((slot < master) && (cyc <= code))
                lvl = level;
            else
                lvl = ~level;
            s_next.drive_low = ~lvl;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign drive_low = s_reg.drive_low;

endmodule

/* verif/led_load.sv */
/*
 * Load model: a pull-up resistor with an LED behind each open-drain output.
 * Assumes oe high means the pin is pulled to the out value, low means released.
 */
`timescale 1ns/1ps

module led_load (
    input  wire logic [8:0] drive_en,
    input  wire logic [8:0] drive_val,
    output logic      [8:0] pin_level
);
    // released pins float up through the resistor, never hold the old value
    assign pin_level = (drive_en & drive_val) | ~drive_en;
endmodule

/* verif/test_led_pwm_intensity_control.sv */
/*
 * Self-checking bench for the LED PWM intensity block: register port checks
 * and low-time counts over whole PWM periods against an integer model.
 * Assumes a short step (STEP_CYCLES = 4) so one period is 960 clocks.
 */
`timescale 1ns/1ps

module test_led_pwm_intensity_control;
    localparam int STEP = 4;
    localparam int PER  = led_pwm_pkg::PERIOD_STEPS * STEP;

    logic        clk;
    logic        rst;
    logic        wr_en;
    logic [7:0]  wr_addr;
    logic [7:0]  wr_data;
    logic        rd_en;
    logic [7:0]  rd_addr;
    logic [7:0]  rd_data;
    logic        rd_valid;
    logic        global_flag;
    logic        blink_enable;
    logic        blink_flip;
    logic [7:0]  phase0;
    logic [7:0]  phase1;
    logic        ninth_phase0;
    logic        ninth_phase1;
    logic [7:0]  port_pin_out;
    logic [7:0]  port_pin_oe;
    logic        ninth_output_out;
    logic        ninth_output_oe;
    logic [8:0]  pin_level;
    logic [31:0] seed = 32'h000154BA;
    logic [7:0]  regs [5];
    int          fail_count = 0;
    int          compares = 0;

    led_pwm_intensity_control #(.STEP_CYCLES(STEP)) dut (
        .clk(clk), .rst(rst), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
        .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
        .global_flag(global_flag), .blink_enable(blink_enable),
        .blink_flip(blink_flip), .phase0(phase0), .phase1(phase1),
        .ninth_phase0(ninth_phase0), .ninth_phase1(ninth_phase1),
        .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe),
        .ninth_output_out(ninth_output_out), .ninth_output_oe(ninth_output_oe)
    );

    led_load load (
        .drive_en({ninth_output_oe, port_pin_oe}),
        .drive_val({ninth_output_out, port_pin_out}),
        .pin_level(pin_level)
    );

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [7:0] addr_of(input int i);
        return (i == 0) ? led_pwm_pkg::MASTER_GLOBAL_ADDR : 8'(8'h0F + i);
    endfunction

    // low steps per period; ungated slots show the inverse level
    function automatic int exp_low(input int m, input int n, input int lvl);
        if (m == 0 || n == 15)
            return lvl ? 0 : led_pwm_pkg::PERIOD_STEPS;
        return lvl ? led_pwm_pkg::PERIOD_STEPS - m * (n + 1) : m * (n + 1);
    endfunction

    task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e)
        begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask

    task automatic chk_low(input string nm, input int e, input int g);
        compares++;
        if (g != e)
        begin
            $display("ERROR %s expected %0d seen %0d", nm, e, g);
            fail_count++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        wr_en = 1'b1;
        wr_addr = a;
        wr_data = d;
        @(negedge clk);
        wr_en = 1'b0;
    endtask

    // read answer comes exactly one clock after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        rd_en = 1'b1;
        rd_addr = a;
        @(negedge clk);
        rd_en = 1'b0;
        chk_reg("rd_valid", 8'h01, {7'h00, rd_valid});
        chk_reg("rd_data", e, rd_data);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        int m;
        int n;
        int lvl;
        int low [9];
        rst = 1'b1;
        wr_en = 1'b0;
        wr_addr = 8'h00;
        wr_data = 8'h00;
        rd_en = 1'b0;
        rd_addr = 8'h00;
        {global_flag, blink_enable, blink_flip, ninth_phase0, ninth_phase1} = 5'h00;
        phase0 = 8'h00;
        phase1 = 8'h00;
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < 5; i++)
            rd_chk(addr_of(i), 8'h00);
        rd_chk(8'h20, led_pwm_pkg::UNMAPPED_READ);
        for (int t = 0; t < 10; t++)
        begin
            for (int i = 0; i < 5; i++)
            begin
                regs[i] = 8'(rnd());
                wr(addr_of(i), regs[i]);
            end
            if (t == 0)
                regs[0][7:4] = 4'h0;
            wr(addr_of(0), regs[0]);
            wr(8'h0F, 8'(rnd()));
            {global_flag, blink_enable, blink_flip, ninth_phase0, ninth_phase1} = 5'(rnd());
            if (t == 1)
                global_flag = 1'b1;
            phase0 = 8'(rnd());
            phase1 = 8'(rnd());
            for (int i = 0; i < 5; i++)
                rd_chk(addr_of(i), regs[i]);
            repeat (12) @(negedge clk);
            low = '{default: 0};
            for (int c = 0; c < PER; c++)
            begin
                @(negedge clk);
                for (int k = 0; k < 9; k++)
                    if (pin_level[k] === 1'b0)
                        low[k]++;
            end
            m = regs[0][7:4];
            for (int k = 0; k < 8; k++)
            begin
                n = (regs[1 + k / 2] >> (4 * (k % 2))) & 15;
                if (global_flag && m != 0)
                    n = regs[0][3:0];
                lvl = (blink_enable && blink_flip) ? phase1[k] : phase0[k];
                chk_low("port_low", exp_low(m, n, lvl) * STEP, low[k]);
            end
            lvl = (blink_enable && blink_flip) ? ninth_phase1 : ninth_phase0;
            chk_low("ninth_low", exp_low(m, regs[0][3:0], lvl) * STEP, low[8]);
        end
        tally_and_finish();
    end
endmodule
